/* File: design/tcu_pixel_map.sv */
// Purpose: Map one shifted pixel group into color and overlay fields
// Assumes: Combinational inputs from the unpacker's held load
// Notes:   Result registered so downstream sees a flop
`timescale 1ns/1ns
`default_nettype none
module tcu_pixel_map
  import tcu_pkg::*;
(
  input  wire logic        pclk,      // Pixel clock
  input  wire logic        presetn,   // Async reset, low
  input  wire tcu_mode_e   mode,      // Decoded mode
  input  wire logic [31:0] word,      // Data-ordered load
  input  wire logic [1:0]  grp,       // Current group index
  input  wire logic        nib_sel,   // Nibble select
  input  wire logic [7:0]  rd_mask,   // Read mask
  output tcu_pix_s         pix        // Registered pixel
);

  typedef struct packed {
    tcu_pix_s pix;
  } tcu_map_state_s;

  tcu_map_state_s st_reg;
  tcu_map_state_s st_next;
  logic [15:0]    half;
  logic [7:0]     byte_sel;

  // Field extraction per mode
  always_comb begin
    st_next = st_reg;
    half = grp[0] ? word[31:16] : word[15:0];
    byte_sel = word[8*grp +: 8];
    st_next.pix = '0;
    case (mode)
      TCU_M_VGA: st_next.pix.vga_sel = 1'b1;
      TCU_M_NIB: st_next.pix.overlay =
        {4'h0, nib_sel ? byte_sel[7:4] : byte_sel[3:0]} & rd_mask;
      TCU_M_15: begin
        st_next.pix.red   = {half[14:10], 3'h0};
        st_next.pix.green = {half[9:5], 3'h0};
        st_next.pix.blue  = {half[4:0], 3'h0};
      end
      TCU_M_16: begin
        st_next.pix.red   = {half[15:11], 3'h0};
        st_next.pix.green = {half[10:5], 2'h0};
        st_next.pix.blue  = {half[4:0], 3'h0};
      end
      TCU_M_6E: begin
        st_next.pix.overlay = word[31:24] & rd_mask;
        st_next.pix.red     = word[23:16];
        st_next.pix.green   = word[15:8];
        st_next.pix.blue    = word[7:0];
      end
      TCU_M_6F: begin
        st_next.pix.blue    = word[31:24];
        st_next.pix.green   = word[23:16];
        st_next.pix.red     = word[15:8];
        st_next.pix.overlay = word[7:0] & rd_mask;
      end
      default: st_next.pix = '0;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pix = st_reg.pix;

endmodule : tcu_pixel_map
`default_nettype wire

/* File: design/tcu_pkg.sv */
// Purpose: Shared constants and types for the true-color pixel unpacker
// Assumes: APB register access, single pclk domain
// Notes:   Register offsets are byte addresses of aligned 32-bit words
package tcu_pkg;

  // Register byte offsets
  localparam logic [7:0] TCU_OFF_MUX     = 8'h00;
  localparam logic [7:0] TCU_OFF_GENCTL  = 8'h04;
  localparam logic [7:0] TCU_OFF_MASK    = 8'h08;
  localparam logic [7:0] TCU_OFF_SHDIV   = 8'h0C;
  localparam logic [7:0] TCU_OFF_STATUS  = 8'h10;

  // Reset values
  localparam logic [7:0] TCU_RST_MUX     = 8'h2D;
  localparam logic [7:0] TCU_RST_GENCTL  = 8'h03;
  localparam logic [7:0] TCU_RST_MASK    = 8'hFF;
  localparam logic [7:0] TCU_RST_SHDIV   = 8'h3F;

  // Mux-control codes on bits 5:0
  localparam logic [5:0] TCU_MUX_VGA     = 6'h2D;
  localparam logic [5:0] TCU_MUX_NIBBLE  = 6'h1F;
  localparam logic [5:0] TCU_MUX_6A      = 6'h08;
  localparam logic [5:0] TCU_MUX_6B      = 6'h09;
  localparam logic [5:0] TCU_MUX_6C      = 6'h0A;
  localparam logic [5:0] TCU_MUX_6D      = 6'h0B;
  localparam logic [5:0] TCU_MUX_6E      = 6'h0E;
  localparam logic [5:0] TCU_MUX_6F      = 6'h0D;

  // Field positions
  localparam int TCU_ENDIAN_BIT = 6;
  localparam int TCU_MODE_MSB   = 5;

  // Group counts per load
  localparam logic [2:0] TCU_GRP_ONE  = 3'h1;
  localparam logic [2:0] TCU_GRP_TWO  = 3'h2;
  localparam logic [2:0] TCU_GRP_FOUR = 3'h4;

  typedef enum logic [2:0] {
    TCU_M_VGA, TCU_M_NIB, TCU_M_15, TCU_M_16, TCU_M_6E, TCU_M_6F, TCU_M_OFF
  } tcu_mode_e;

  // One displayed pixel toward the converters
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] overlay;
    logic       vga_sel;
  } tcu_pix_s;

endpackage : tcu_pkg

/* File: design/tcu_unpacker.sv */
// Purpose: True-color and nibble pixel unpacker with APB registers
// Assumes: Shift clock, nibble flag, pixel bus asynchronous to pclk
// Notes:   pclk serves as pixel clock; one group is shown per cycle
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Mux code 0x2D selects VGA pass-through, pixel path unused.
// - Bits 5:0 decode submodes; 6c taken as 001010; bits 7:6 ignored.
// - 6a/6b one halfword, 6c/6d two halfwords low first, 6e/6f one word.
// - All groups latched on shift edge, shown one per pixel cycle.
// - One shift pulse per load; divide equals pixels per load.
// - 24-bit 6f: top byte blue, next green, third red; 6e byte-reversed; palette bypassed.
// - Lowest byte (6f) or top byte (6e) is overlay; zero byte or cleared mask disables it.
// - Nibble mode uses sixteen of thirty-two bus bits, four pixels.
// - Nibble flag picks upper or lower nibble of each byte.
// - 15-bit and 16-bit halfwords split into red, green, blue fields.
// - Control bit 6 chooses big endian, bit-reversing pixel inputs.
// - Read mask ANDs each address bit, zero mask gives location zero.
module tcu_unpacker
  import tcu_pkg::*;
(
  input  wire logic        pclk,         // Pixel and bus clock
  input  wire logic        presetn,      // Async reset, low
  input  wire logic [31:0] paddr,        // APB address
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction
  input  wire logic [31:0] pwdata,       // APB write data
  output logic [31:0]      prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  input  wire logic [31:0] pixel_bus,    // Frame-buffer pixel inputs
  input  wire logic        shift_clk,    // Shift clock from load side
  input  wire logic        nibble_select_flag, // Nibble choice
  output logic             shift_req,    // One pulse per bus load
  output logic [7:0]       pal_addr,     // Masked palette address
  output tcu_pix_s         pix_out,      // Pixel to converters
  output logic             pix_valid     // Group shown this cycle
);

  typedef struct packed {
    logic [7:0]  mux_reg;
    logic [7:0]  general_control_reg;
    logic [7:0]  mask_reg;
    logic [7:0]  shdiv_reg;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  sclk_sync;
    logic        sclk_prev;
    logic [1:0]  nib_sync;
    logic [1:0][31:0] pix_sync;
    logic [31:0] load;
    logic [2:0]  grp_cnt;
    logic [2:0]  grp_idx;
    logic        busy;
    logic [7:0]  div_cnt;
    logic        shift_req;
    logic [7:0]  pal_addr;
    logic        pix_valid;
    logic [7:0]  page_reg;
  } tcu_state_s;

  tcu_state_s  st_reg;
  tcu_state_s  st_next;
  tcu_mode_e   mode;
  logic [31:0] ordered;
  logic [2:0]  groups;
  logic        sclk_rise;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  addr8;
  logic [7:0]  pal_raw;
  tcu_pix_s    map_pix;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    case (st_reg.mux_reg[TCU_MODE_MSB:0])
      TCU_MUX_VGA:    mode = TCU_M_VGA;
      TCU_MUX_NIBBLE: mode = TCU_M_NIB;
      TCU_MUX_6A:     mode = TCU_M_15;
      TCU_MUX_6C:     mode = TCU_M_15;
      TCU_MUX_6B:     mode = TCU_M_16;
      TCU_MUX_6D:     mode = TCU_M_16;
      TCU_MUX_6E:     mode = TCU_M_6E;
      TCU_MUX_6F:     mode = TCU_M_6F;
      default:        mode = TCU_M_OFF;
    endcase
  end

  // Groups per load
  always_comb begin
    case (st_reg.mux_reg[TCU_MODE_MSB:0])
      TCU_MUX_6C:     groups = TCU_GRP_TWO;
      TCU_MUX_6D:     groups = TCU_GRP_TWO;
      TCU_MUX_NIBBLE: groups = TCU_GRP_FOUR;
      default:        groups = TCU_GRP_ONE;
    endcase
  end

  // Endian ordering of pixel inputs
  generate
    for (genvar i = 0; i < 32; i++) begin : g_endian
      assign ordered[i] =
        st_reg.general_control_reg[TCU_ENDIAN_BIT] ? st_reg.pix_sync[1][31-i]
                                                   : st_reg.pix_sync[1][i];
    end
  endgenerate

  assign sclk_rise = st_reg.sclk_sync[1] & ~st_reg.sclk_prev;
  assign addr8     = paddr[7:0];
  assign wr_en     = psel & penable & pwrite & st_reg.pready;
  assign rd_en     = psel & ~penable & ~pwrite;
  assign pal_raw   = (st_reg.page_reg | map_pix.overlay) & st_reg.mask_reg;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.sclk_sync = {st_reg.sclk_sync[0], shift_clk};
    st_next.sclk_prev = st_reg.sclk_sync[1];
    st_next.nib_sync  = {st_reg.nib_sync[0], nibble_select_flag};
    st_next.pix_sync  = {st_reg.pix_sync[0], pixel_bus}; // Same age as strobe
    st_next.shift_req = 1'b0;
    st_next.pix_valid = 1'b0;
    st_next.pal_addr  = pal_raw;

    // APB: ready in access phase, one wait-free cycle
    st_next.pready  = psel & ~penable;
    st_next.pslverr = 1'b0;
    if (rd_en) begin
      case (addr8)
        TCU_OFF_MUX:    st_next.prdata = {24'h0, st_reg.mux_reg};
        TCU_OFF_GENCTL: st_next.prdata = {24'h0, st_reg.general_control_reg};
        TCU_OFF_MASK:   st_next.prdata = {24'h0, st_reg.mask_reg};
        TCU_OFF_SHDIV:  st_next.prdata = {24'h0, st_reg.shdiv_reg};
        TCU_OFF_STATUS: st_next.prdata =
          {24'h0, st_reg.busy, st_reg.grp_idx, 1'b0, st_reg.grp_cnt};
        default: begin
          st_next.prdata  = 32'h0;
          st_next.pslverr = 1'b1;
        end
      endcase
    end else if (psel & ~penable) begin
      st_next.pslverr = ~(addr8 == TCU_OFF_MUX || addr8 == TCU_OFF_GENCTL ||
                          addr8 == TCU_OFF_MASK || addr8 == TCU_OFF_SHDIV);
    end
    if (wr_en) begin
      case (addr8)
        TCU_OFF_MUX: begin
          st_next.mux_reg = pwdata[7:0];
          // Selecting VGA acts as software reset
          if (pwdata[TCU_MODE_MSB:0] == TCU_MUX_VGA) begin
            st_next.general_control_reg = TCU_RST_GENCTL;
            st_next.mask_reg  = TCU_RST_MASK;
            st_next.shdiv_reg = TCU_RST_SHDIV;
            st_next.busy      = 1'b0;
            st_next.div_cnt   = '0;
          end
        end
        TCU_OFF_GENCTL: st_next.general_control_reg = pwdata[7:0];
        TCU_OFF_MASK:   st_next.mask_reg = pwdata[7:0];
        TCU_OFF_SHDIV:  st_next.shdiv_reg = pwdata[7:0];
        default: st_next.mux_reg = st_reg.mux_reg;
      endcase
    end

    if (mode != TCU_M_VGA && mode != TCU_M_OFF) begin
      if (st_reg.div_cnt + 8'h01 >= st_reg.shdiv_reg) begin
        st_next.div_cnt   = '0;
        st_next.shift_req = 1'b1;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 8'h01;
      end
    end

    if (sclk_rise && mode != TCU_M_VGA) begin
      st_next.load    = ordered;
      st_next.grp_cnt = groups;
      st_next.grp_idx = '0;
      st_next.busy    = 1'b1;
    end else if (st_reg.busy) begin
      st_next.pix_valid = 1'b1;
      if (st_reg.grp_idx + 3'h1 >= st_reg.grp_cnt) begin
        st_next.busy = 1'b0;
      end else begin
        st_next.grp_idx = st_reg.grp_idx + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.mux_reg <= TCU_RST_MUX;
      st_reg.general_control_reg <= TCU_RST_GENCTL;
      st_reg.mask_reg <= TCU_RST_MASK;
      st_reg.shdiv_reg <= TCU_RST_SHDIV;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field mapping of the current group
  tcu_pixel_map u_map (
    .pclk    (pclk),
    .presetn (presetn),
    .mode    (mode),
    .word    (st_reg.load),
    .grp     (st_reg.grp_idx[1:0]),
    .nib_sel (st_reg.nib_sync[1]),
    .rd_mask (st_reg.mask_reg),
    .pix     (map_pix)
  );

  // Outputs from flops
  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign pslverr   = st_reg.pslverr;
  assign shift_req = st_reg.shift_req;
  assign pal_addr  = st_reg.pal_addr;
  assign pix_out   = map_pix;
  assign pix_valid = st_reg.pix_valid;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_vga_mode;
    @(posedge pclk) disable iff (!presetn)
      (mode == TCU_M_VGA) |=> pix_out.vga_sel && !shift_req &&
        $stable(st_reg.load);
  endproperty
  a_vga_mode: assert property (p_vga_mode)
    else $error("vga decode wrong");

  property p_decode;
    @(posedge pclk) disable iff (!presetn)
      (st_reg.mux_reg[5:0] == 6'h0E) |-> (mode == TCU_M_6E);
  endproperty
  a_decode: assert property (p_decode)
    else $error("6e decode wrong");

  property p_two_groups;
    @(posedge pclk) disable iff (!presetn)
      (sclk_rise && st_reg.mux_reg[5:0] == 6'h0B) |=> (st_reg.grp_cnt == 3'h2);
  endproperty
  a_two_groups: assert property (p_two_groups)
    else $error("6d group count wrong");

  property p_shift_out;
    @(posedge pclk) disable iff (!presetn)
      (sclk_rise && mode != TCU_M_VGA) |=> st_reg.busy && st_reg.grp_idx == 0;
  endproperty
  a_shift_out: assert property (p_shift_out)
    else $error("load not started at group zero");

  property p_divide;
    @(posedge pclk) disable iff (!presetn)
      shift_req |-> st_reg.div_cnt == 8'h00;
  endproperty
  a_divide: assert property (p_divide)
    else $error("shift pulse off divide");

  property p_endian;
    @(posedge pclk) disable iff (!presetn)
      st_reg.general_control_reg[TCU_ENDIAN_BIT] |->
        ordered[0] == st_reg.pix_sync[1][31];
  endproperty
  a_endian: assert property (p_endian)
    else $error("endian order wrong");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
      (st_reg.mask_reg == 8'h00) |=> (pal_addr == 8'h00);
  endproperty
  a_mask: assert property (p_mask)
    else $error("zero mask not location zero");

  property p_valid_count;
    @(posedge pclk) disable iff (!presetn)
      (sclk_rise && mode == TCU_M_NIB) ##1 (!sclk_rise)[*4] |->
        $past(pix_valid, 1) && $past(pix_valid, 2);
  endproperty
  a_valid_count: assert property (p_valid_count)
    else $error("nibble groups not shown");

  property p_nib_low;
    @(posedge pclk) disable iff (!presetn)
      (mode == TCU_M_NIB && st_reg.busy && !sclk_rise &&
       st_reg.grp_idx == 3'h0 && !st_reg.nib_sync[1] &&
       st_reg.mask_reg == TCU_RST_MASK) |=>
        pix_out.overlay == {4'h0, st_reg.load[3:0]};
  endproperty
  a_nib_low: assert property (p_nib_low)
    else $error("nibble low pick wrong");

  property p_nib_high;
    @(posedge pclk) disable iff (!presetn)
      (mode == TCU_M_NIB && st_reg.busy && !sclk_rise &&
       st_reg.grp_idx == 3'h0 && st_reg.nib_sync[1] &&
       st_reg.mask_reg == TCU_RST_MASK) |=>
        pix_out.overlay == {4'h0, st_reg.load[7:4]};
  endproperty
  a_nib_high: assert property (p_nib_high)
    else $error("nibble high pick wrong");

  property p_half_order;
    @(posedge pclk) disable iff (!presetn)
      (mode == TCU_M_16 && st_reg.busy && !sclk_rise &&
       st_reg.grp_idx == 3'h1) |=> pix_out.blue[7:3] == st_reg.load[20:16];
  endproperty
  a_half_order: assert property (p_half_order)
    else $error("second halfword wrong");

  property p_true_bytes;
    @(posedge pclk) disable iff (!presetn)
      (mode == TCU_M_6F && st_reg.busy && !sclk_rise) |=>
        pix_out.blue == st_reg.load[31:24] &&
        pix_out.red == st_reg.load[15:8];
  endproperty
  a_true_bytes: assert property (p_true_bytes)
    else $error("true color bytes misrouted");

  property p_mask_overlay;
    @(posedge pclk) disable iff (!presetn)
      (st_reg.mask_reg == 8'h00) |=> (pix_out.overlay == 8'h00);
  endproperty
  a_mask_overlay: assert property (p_mask_overlay)
    else $error("overlay not cleared by mask");

  property p_valid_busy;
    @(posedge pclk) disable iff (!presetn)
      pix_valid |-> $past(st_reg.busy);
  endproperty
  a_valid_busy: assert property (p_valid_busy)
    else $error("group shown without load");

endmodule : tcu_unpacker
`default_nettype wire

/* File: testbench/tb_tcu_unpacker.sv */
// Purpose: Self-checking bench for the pixel unpacker
// Assumes: Frame-buffer model answers the shift requests
// Notes:   Random words from a fixed LFSR seed
`timescale 1ns/1ns
`default_nettype none
module tb_tcu_unpacker
  import tcu_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, shift_clk, nflag;
  logic [31:0] paddr, pwdata, prdata, pixel_bus, seed, rd;
  logic        pready, pslverr, shift_req, pix_valid, err;
  logic [7:0]  pal_addr;
  tcu_pix_s    pix_out;
  int          errors, check_count, cyc, k, i, b;
  logic [5:0]  mt [7] = '{TCU_MUX_6A, TCU_MUX_6B, TCU_MUX_6C, TCU_MUX_6D,
                          TCU_MUX_6E, TCU_MUX_6F, TCU_MUX_NIBBLE};
  int          gn [7] = '{1, 1, 2, 2, 1, 1, 4};
  logic [7:0]  offs [4] = '{TCU_OFF_MUX, TCU_OFF_GENCTL, TCU_OFF_MASK,
                            TCU_OFF_SHDIV};
  logic [7:0]  rsts [4] = '{TCU_RST_MUX, TCU_RST_GENCTL, TCU_RST_MASK,
                            TCU_RST_SHDIV};

  tcu_unpacker u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pixel_bus(pixel_bus),
    .shift_clk(shift_clk), .nibble_select_flag(nflag),
    .shift_req(shift_req), .pal_addr(pal_addr), .pix_out(pix_out),
    .pix_valid(pix_valid)
  );

  tcu_vram_model u_vram (
    .pclk(pclk), .shift_req(shift_req), .pixel_bus(pixel_bus),
    .shift_clk(shift_clk)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected pixel for one group
  function automatic tcu_pix_s exp_pix(input logic [5:0] m,
    input logic [31:0] w, input logic be, input int g, input logic f,
    input logic [7:0] mk);
    tcu_pix_s    p;
    logic [31:0] d;
    logic [15:0] h;
    p = '0;
    d = w;
    if (be) for (int n = 0; n < 32; n++) d[n] = w[31 - n];
    h = (g == 1) ? d[31:16] : d[15:0];
    case (m)
      TCU_MUX_6A, TCU_MUX_6C: begin
        p.red   = {h[14:10], 3'h0};
        p.green = {h[9:5], 3'h0};
        p.blue  = {h[4:0], 3'h0};
      end
      TCU_MUX_6B, TCU_MUX_6D: begin
        p.red   = {h[15:11], 3'h0};
        p.green = {h[10:5], 2'h0};
        p.blue  = {h[4:0], 3'h0};
      end
      TCU_MUX_6E: begin
        p.overlay = d[31:24] & mk;
        p.red     = d[23:16];
        p.green   = d[15:8];
        p.blue    = d[7:0];
      end
      TCU_MUX_6F: begin
        p.blue    = d[31:24];
        p.green   = d[23:16];
        p.red     = d[15:8];
        p.overlay = d[7:0] & mk;
      end
      default: begin
        p.overlay = {4'h0, d[8 * g + 4 * f +: 4]} & mk;
      end
    endcase
    return p;
  endfunction : exp_pix

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {24'h0, a};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Program a mode, send one load, check every group
  task automatic run_load(input logic [5:0] m, input int ng,
    input logic be, input logic [7:0] mk);
    logic [31:0] w;
    tcu_pix_s    s;
    tcu_pix_s    e;
    int          g;
    logic        pv;
    logic [7:0]  po;
    seed = lfsr(seed);
    apb(1'b1, TCU_OFF_MUX, {24'h0, seed[7:6], m});
    apb(1'b1, TCU_OFF_GENCTL, be ? 32'h43 : 32'h03);
    apb(1'b1, TCU_OFF_MASK, {24'h0, mk});
    apb(1'b1, TCU_OFF_SHDIV, 32'(ng));
    seed = lfsr(seed);
    w = seed;
    nflag <= seed[9];
    u_vram.lag = int'(seed[11]);
    repeat (4) @(posedge pclk);
    u_vram.push(w);
    g = 0;
    pv = 1'b0;
    po = 8'h00;
    for (int n = 0; n < 60; n++) begin
      @(posedge pclk);
      // Palette address lags the shown group by one cycle
      if (pv) chk(pal_addr, po);
      pv = (pix_valid === 1'b1);
      if (pix_valid === 1'b1) begin
        s = pix_out;
        e = exp_pix(m, w, be, g, nflag, mk);
        po = e.overlay & mk;
        chk(s, e);
        if (mk == 8'h00) chk(pal_addr, 64'h0);
        g++;
      end
    end
    chk(g, ng);
  endtask : run_load

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    nflag = 1'b0;
    errors = 0;
    check_count = 0;
    cyc = 0;
    seed = 32'h6626;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b0, offs[i], 32'h0);
      chk({rd, 31'h0, err}, {24'h0, rsts[i], 32'h0});
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({rd, 31'h0, err}, 64'h1);
    for (b = 0; b < 2; b++)
      for (i = 0; i < 7; i++)
        if (!(b == 1 && i == 6)) run_load(mt[i], gn[i], b[0], 8'hFF);
    run_load(TCU_MUX_6F, 1, 1'b0, 8'h00);
    // Divide of eight for the pulse period check
    apb(1'b1, TCU_OFF_SHDIV, 32'h8);
    repeat (2) @(posedge pclk);
    for (k = 0; k < 50 && shift_req !== 1'b1; k++) @(posedge pclk);
    for (k = 1; k < 50; k++) begin
      @(posedge pclk);
      if (shift_req === 1'b1) break;
    end
    chk(k, 8);
    apb(1'b1, TCU_OFF_MASK, 32'h5A);
    apb(1'b1, TCU_OFF_MUX, {26'h0, TCU_MUX_VGA});
    apb(1'b0, TCU_OFF_MASK, 32'h0);
    chk(rd, TCU_RST_MASK);
    u_vram.push(seed);
    for (k = 0; k < 30; k++) begin
      @(posedge pclk);
      chk({pix_valid, shift_req, pix_out.vga_sel}, 3'b001);
    end
    tally_and_finish();
  end
endmodule : tb_tcu_unpacker
`default_nettype wire

/* File: testbench/tcu_vram_model.sv */
// Purpose: Frame-buffer model feeding the pixel bus on shift requests
// Assumes: One queued word per shift request, queue filled by the bench
// Notes:   Data goes to its inverse once the hold time has run out
`timescale 1ns/1ns
`default_nettype none
module tcu_vram_model (
  input  wire logic        pclk,      // Pixel clock
  input  wire logic        shift_req, // Load request from device
  output logic [31:0]      pixel_bus, // Pixel data toward device
  output logic             shift_clk  // Load strobe toward device
);
  logic [31:0] q [$];
  int          lag = 0;

  // Queue one bus load
  task automatic push(input logic [31:0] w);
    q.push_back(w);
  endtask : push

  ////////////////////////////////////////////////////////////////////////
  // Whole load on one rise
  initial begin
    pixel_bus = 32'h0;
    shift_clk = 1'b0;
    forever begin
      @(posedge pclk);
      if (shift_req === 1'b1 && q.size() > 0) begin
        repeat (lag) @(posedge pclk);
        pixel_bus <= q.pop_front();
        shift_clk <= 1'b1;
        repeat (2) @(posedge pclk);
        shift_clk <= 1'b0;
        repeat (4) @(posedge pclk);
        pixel_bus <= ~pixel_bus;  // Hold over, stale data
      end
    end
  end
endmodule : tcu_vram_model
`default_nettype wire
